// File: psw_mem_model.sv
// Purpose: Data memory on the far side of the status block
// Assumes: Bench presets words through the ram array
// Notes: Read is combinational; no wait states modelled
`timescale 1ns/1ps
module psw_mem_model (
   input  wire logic        clk,
   input  wire logic        we,
   input  wire logic [7:0]  waddr,
   input  wire logic [15:0] wdata,
   input  wire logic [7:0]  raddr,
   output logic [15:0]      rdata
);
   logic [15:0] ram [0:255];
   // Plain always so the bench may also preset words
   always @(posedge clk) begin
      if (we) ram[waddr] <= wdata;
   end
   assign rdata = ram[raddr];
endmodule : psw_mem_model

// File: psw_pkg.sv
// Purpose: Constants for the processor status word block
// Assumes: One core clock, synchronous active-high reset
// Notes: Store image layout and page constants live here
// Functional notes
// - Five status bits, each separately changeable
// - Status load updates all bits but mask
// - Mask set/cleared by instructions, set by reset
// - Interrupt entry sets the mask first
// - Mask blocks maskable interrupts, never reset
// - Pointer bit picks aux register zero or one
// - Pointer changes on indirect, pointer, status loads
// - Wrap flag sticky until reset, branch, load
// - Clamp mode saturates overflowed accumulator results
// - Clamp bit set, cleared, or loaded
// - Status store leaves live bits untouched
// - Direct status store always targets page one
// - Indirect status store uses selected aux register
// - Store image bit positions fixed
// - Reserved image positions read as one, except bit 1 which reads as zero
// - Reset leaves pointer, page, clamp bits alone
package psw_pkg;
   localparam int          WRAP_POS  = 15;
   localparam int          CLAMP_POS = 14;
   localparam int          MASK_POS  = 13;
   localparam int          AUXP_POS  = 8;
   localparam int          PAGE_POS  = 0;
   localparam int          ZERO_POS  = 1;
   localparam logic [15:0] IMG_FILL  = 16'h1EFC;
   localparam logic        STORE_PAGE = 1'b1;
   localparam logic [15:0] ACC_MAX   = 16'h7FFF;
   localparam logic [15:0] ACC_MIN   = 16'h8000;
endpackage : psw_pkg

// File: psw_status.sv
// Purpose: Processor status word with load, store and address forming
// Assumes: Decoder gives one-cycle instruction strobes; all on clk
// Notes: Accumulator result is saturated here for the core
`timescale 1ns/1ps
module psw_status
   import psw_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load_status_instr,
   input  wire logic        store_status_instr,
   input  wire logic        indirect_mode,
   input  wire logic        ptr_change_req,
   input  wire logic        new_ptr,
   input  wire logic        load_aux_ptr_instr,
   input  wire logic        modify_aux_reg_instr,
   input  wire logic        load_page_instr,
   input  wire logic        load_page_imm_instr,
   input  wire logic        irq_mask_instr,
   input  wire logic        irq_unmask_instr,
   input  wire logic        set_clamp_instr,
   input  wire logic        clear_clamp_instr,
   input  wire logic        branch_on_wrap_instr,
   input  wire logic        irq_service,
   input  wire logic        irq_request,
   input  wire logic        acc_overflow,
   input  wire logic        acc_neg_overflow,
   input  wire logic [15:0] acc_result,
   input  wire logic [15:0] mem_rdata,
   input  wire logic [6:0]  instr_offset,
   input  wire logic [7:0]  aux_reg_zero,
   input  wire logic [7:0]  aux_reg_one,
   output logic [7:0]       data_addr,
   output logic             mem_we,
   output logic [15:0]      mem_wdata,
   output logic [15:0]      acc_out,
   output logic             irq_take,
   output logic             wrap_out,
   output logic             mask_out,
   output logic             clamp_out,
   output logic             auxp_out,
   output logic             page_out
);
   logic        wrap_r, wrap_nxt;
   logic        mask_r, mask_nxt;
   logic        clamp_r, clamp_nxt;
   logic        auxp_r, auxp_nxt;
   logic        page_r, page_nxt;
   logic [7:0]  addr_r, addr_nxt;
   logic        we_r, we_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic [15:0] acc_r, acc_nxt;
   logic        take_r, take_nxt;

   function automatic logic [15:0] status_image(input logic w, input logic c,
                                               input logic m, input logic a,
                                               input logic p);
      logic [15:0] img;
      img = IMG_FILL;
      img[WRAP_POS]  = w;
      img[CLAMP_POS] = c;
      img[MASK_POS]  = m;
      img[AUXP_POS]  = a;
      img[ZERO_POS]  = 1'b0;
      img[PAGE_POS]  = p;
      return img;
   endfunction : status_image

   always_comb begin
      wrap_nxt  = wrap_r;
      mask_nxt  = mask_r;
      clamp_nxt = clamp_r;
      auxp_nxt  = auxp_r;
      page_nxt  = page_r;
      if (load_status_instr) begin
         wrap_nxt  = mem_rdata[WRAP_POS];
         clamp_nxt = mem_rdata[CLAMP_POS];
         auxp_nxt  = mem_rdata[AUXP_POS];
         page_nxt  = mem_rdata[PAGE_POS];
      end
      if (branch_on_wrap_instr)
         wrap_nxt = 1'b0;
      // Overflow in the same cycle as a clear still sticks
      if (acc_overflow)
         wrap_nxt = 1'b1;
      if (irq_unmask_instr)
         mask_nxt = 1'b0;
      if (irq_mask_instr || irq_service)
         mask_nxt = 1'b1;
      if (set_clamp_instr)
         clamp_nxt = 1'b1;
      if (clear_clamp_instr)
         clamp_nxt = 1'b0;
      if (load_aux_ptr_instr || modify_aux_reg_instr || (indirect_mode && ptr_change_req))
         auxp_nxt = new_ptr;
      if (load_page_instr || load_page_imm_instr)
         page_nxt = mem_rdata[PAGE_POS];
      if (rst) begin
         wrap_nxt = 1'b0;
         mask_nxt = 1'b1;
         // Pointer, page and clamp untouched by reset
         auxp_nxt  = auxp_r;
         page_nxt  = page_r;
         clamp_nxt = clamp_r;
      end
   end

   always_comb begin
      addr_nxt  = {page_r, instr_offset};
      if (indirect_mode)
         addr_nxt = auxp_r ? aux_reg_one : aux_reg_zero;
      else if (store_status_instr)
         addr_nxt = {STORE_PAGE, instr_offset};
      we_nxt    = store_status_instr && !rst;
      wdata_nxt = status_image(wrap_r, clamp_r, mask_r, auxp_r, page_r);
      acc_nxt   = acc_result;
      if (acc_overflow && clamp_r)
         acc_nxt = acc_neg_overflow ? ACC_MIN : ACC_MAX;
      take_nxt  = irq_request && !mask_r && !rst;
   end

   // Status bits have no reset branch; rst clears wrap and sets mask through the next-state logic
   always_ff @(posedge clk) begin
      wrap_r  <= wrap_nxt;
      mask_r  <= mask_nxt;
      clamp_r <= clamp_nxt;
      auxp_r  <= auxp_nxt;
      page_r  <= page_nxt;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r  <= 8'h00;
         we_r    <= 1'b0;
         wdata_r <= 16'h0000;
         acc_r   <= 16'h0000;
         take_r  <= 1'b0;
      end else begin
         addr_r  <= addr_nxt;
         we_r    <= we_nxt;
         wdata_r <= wdata_nxt;
         acc_r   <= acc_nxt;
         take_r  <= take_nxt;
      end
   end

   assign data_addr = addr_r;
   assign mem_we    = we_r;
   assign mem_wdata = wdata_r;
   assign acc_out   = acc_r;
   assign irq_take  = take_r;
   assign wrap_out  = wrap_r;
   assign mask_out  = mask_r;
   assign clamp_out = clamp_r;
   assign auxp_out  = auxp_r;
   assign page_out  = page_r;

   a_mask_after_reset: assert property (@(posedge clk) rst |=> mask_out && !wrap_out)
      else $error("reset did not set mask or clear wrap");
   a_wrap_sticky: assert property (@(posedge clk) disable iff (rst)
      wrap_out && !load_status_instr && !branch_on_wrap_instr |=> wrap_out)
      else $error("wrap flag dropped");
   a_wrap_set: assert property (@(posedge clk) disable iff (rst) acc_overflow |=> wrap_out)
      else $error("overflow not flagged");
   a_load_keeps_mask: assert property (@(posedge clk) disable iff (rst)
      load_status_instr && !irq_mask_instr && !irq_unmask_instr && !irq_service
      |=> mask_out == $past(mask_out))
      else $error("status load changed mask");
   a_service_masks: assert property (@(posedge clk) disable iff (rst) irq_service |=> mask_out)
      else $error("interrupt entry left mask clear");
   a_mask_blocks: assert property (@(posedge clk) disable iff (rst)
      mask_out |=> !irq_take)
      else $error("masked interrupt taken");
   a_store_image: assert property (@(posedge clk) disable iff (rst)
      store_status_instr |=> mem_we && mem_wdata[12:9] == 4'hF && !mem_wdata[1]
      && mem_wdata[15] == $past(wrap_out) && mem_wdata[8] == $past(auxp_out))
      else $error("bad status image");
   a_store_page: assert property (@(posedge clk) disable iff (rst)
      store_status_instr && !indirect_mode |=> data_addr == {1'b1, $past(instr_offset)})
      else $error("direct store not on page one");
   a_store_keeps: assert property (@(posedge clk) disable iff (rst)
      store_status_instr && !load_status_instr && !load_page_instr && !load_page_imm_instr
      |=> page_out == $past(page_out))
      else $error("store altered page bit");
   a_clamp_sat: assert property (@(posedge clk) disable iff (rst)
      acc_overflow && clamp_out && !acc_neg_overflow |=> acc_out == 16'h7FFF)
      else $error("no positive saturation");
endmodule : psw_status

// File: test_psw_status.sv
// Purpose: Self-checking bench for the status word block
// Assumes: Strobes are one-cycle pulses; outputs settle one edge later
// Notes: Strobe vector bit order follows the instance connections
`timescale 1ns/1ps
module test_psw_status;
   import psw_pkg::*;
   typedef struct packed {logic [11:0] s; logic n; logic o; logic [15:0] d; logic [4:0] e;} psw_row_t;
   logic        clk = 0, rst = 1, ind = 0, np = 0, irq = 0, ovf = 0, pc = 0;
   logic [11:0] s   = '0;
   logic [15:0] acc = 16'h0000;
   logic [15:0] wd, ao, rd;
   logic [7:0]  da;
   logic        we, tk, w, c, m, g, p;
   int          errors = 0, check_count = 0, cyc = 0;
   psw_row_t    rows [15] = '{
      '{12'h001,0,0,16'h0000,5'h04}, '{12'h080,0,0,16'h0000,5'h00},
      '{12'h040,0,0,16'h0000,5'h04}, '{12'h080,0,0,16'h0000,5'h00},
      '{12'h100,0,0,16'h0000,5'h08}, '{12'h200,0,0,16'h0000,5'h00},
      '{12'h004,1,0,16'h0000,5'h02}, '{12'h008,0,0,16'h0000,5'h00},
      '{12'h010,0,0,16'h0001,5'h01}, '{12'h020,0,0,16'h0000,5'h00},
      '{12'h000,0,1,16'h0000,5'h10}, '{12'h400,0,0,16'h0000,5'h00},
      '{12'h000,0,1,16'h0000,5'h10}, '{12'h001,0,0,16'h6101,5'h0B},
      '{12'h001,0,0,16'h8000,5'h10}};
   psw_status psw_status_i (.clk(clk), .rst(rst), .load_status_instr(s[0]),
      .store_status_instr(s[1]), .load_aux_ptr_instr(s[2]), .modify_aux_reg_instr(s[3]),
      .load_page_instr(s[4]), .load_page_imm_instr(s[5]), .irq_mask_instr(s[6]),
      .irq_unmask_instr(s[7]), .set_clamp_instr(s[8]), .clear_clamp_instr(s[9]),
      .branch_on_wrap_instr(s[10]), .irq_service(s[11]), .indirect_mode(ind),
      .ptr_change_req(pc), .new_ptr(np), .irq_request(irq), .acc_overflow(ovf),
      .acc_neg_overflow(1'b0), .acc_result(acc), .mem_rdata(rd), .instr_offset(7'h05),
      .aux_reg_zero(8'h11), .aux_reg_one(8'h3C), .data_addr(da), .mem_we(we),
      .mem_wdata(wd), .acc_out(ao), .irq_take(tk), .wrap_out(w), .mask_out(m),
      .clamp_out(c), .auxp_out(g), .page_out(p));
   psw_mem_model mem_i (.clk(clk), .we(we), .waddr(da), .wdata(wd), .raddr(8'h00),
      .rdata(rd));
   always #2.5 clk = ~clk;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task step(input logic [11:0] v, input logic n, input logic o);
      @(posedge clk);
      s <= v;
      np <= n;
      ovf <= o;
      @(posedge clk);
      s <= '0;
      ovf <= 1'b0;
      #1;
   endtask : step
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc++;
      if (cyc == 500) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 15; i++) begin
         mem_i.ram[0] = rows[i].d;
         step(rows[i].s, rows[i].n, rows[i].o);
         chk(16'({w, c, m, g, p}), 16'(rows[i].e));
      end
      $display("test rows finished");
      step(12'h040, 0, 0);
      @(posedge clk) irq <= 1'b1;
      step(12'h000, 0, 0);
      chk(16'(tk), 16'h0000);
      step(12'h080, 0, 0);
      @(posedge clk) #1;
      chk(16'(tk), 16'h0001);
      step(12'h800, 0, 0);
      chk(16'(m), 16'h0001);
      $display("test mask finished");
      step(12'h002, 0, 0);
      chk({we, 7'h00, da}, 16'h8085);
      chk(wd, 16'hBEFC);
      chk(16'({w, c, m, g, p}), 16'h0014);
      @(posedge clk) #1;
      chk(mem_i.ram[8'h85], 16'hBEFC);
      step(12'h004, 1, 0);
      @(posedge clk) ind <= 1'b1;
      step(12'h002, 0, 0);
      chk({8'h00, da}, 16'h003C);
      chk(wd, 16'hBFFC);
      pc <= 1'b1;
      step(12'h000, 0, 0);
      chk(16'(g), 16'h0000);
      pc <= 1'b0;
      ind <= 1'b0;
      $display("test store finished");
      @(posedge clk) acc <= 16'h1234;
      step(12'h100, 0, 0);
      step(12'h000, 0, 1);
      chk(ao, 16'h7FFF);
      step(12'h200, 0, 0);
      step(12'h000, 0, 1);
      chk(ao, 16'h1234);
      $display("test clamp finished");
      mem_i.ram[0] = 16'h0001;
      step(12'h020, 0, 0);
      step(12'h080, 0, 0);
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(16'({w, c, m, g, p}), 16'h0005);
      @(posedge clk) #1;
      chk({8'h00, da}, 16'h0085);
      $display("test reset finished");
      end_sim();
   end
endmodule : test_psw_status
